// *** chlt_pkg.sv ***
// Purpose: Shared constants and types of the charger limit and timing register group
// Assumes: SMBus command codes select the registers; word data is 16 bits
// Notes:   Voltage codes are 8 mV per step, threshold codes 128 mA per step
`default_nettype none
package chlt_pkg;

   // ------------------------------------------------------------
   // Command codes
   // ------------------------------------------------------------
   localparam logic [7:0]  CMD_UPPER_V    = 8'h15;
   localparam logic [7:0]  CMD_DURATIONS  = 8'h38;
   localparam logic [7:0]  CMD_LOWER_V    = 8'h3E;
   localparam logic [7:0]  CMD_ALERT_THR  = 8'h47;

   // ------------------------------------------------------------
   // Field positions and limits
   // ------------------------------------------------------------
   localparam int          VOLT_LSB_POS   = 3;
   localparam int          VOLT_MSB_POS   = 13;
   localparam logic [10:0] VOLT_MAX_CODE  = 11'h6C0;   // 13824 mV
   localparam int          THR_LSB_POS    = 7;
   localparam int          THR_MSB_POS    = 12;
   localparam logic [5:0]  THR_MAX_CODE   = 6'h32;     // 6400 mA
   localparam int          DUR1_LSB_POS   = 0;
   localparam int          DUR1_MSB_POS   = 2;
   localparam int          DUR2_LSB_POS   = 8;
   localparam int          DUR2_MSB_POS   = 10;
   localparam int          CTL_DEB_LSB    = 9;
   localparam int          CTL_DEB_MSB    = 10;
   localparam int          CTL_HOLD_LSB   = 6;
   localparam int          CTL_HOLD_MSB   = 8;
   localparam int          BYTE_BITS      = 8;
   localparam logic [3:0]  ACK_SLOT       = 4'h8;
   localparam logic [3:0]  ACK_DONE       = 4'h9;

   // ------------------------------------------------------------
   // Values after reset
   // ------------------------------------------------------------
   localparam logic [15:0] RST_UPPER_V    = 16'h0000;
   localparam logic [15:0] RST_LOWER_V    = 16'h0000;
   localparam logic [15:0] RST_DURATIONS  = 16'h0000;
   localparam logic [15:0] RST_ALERT_THR  = 16'h0C00;

   // ------------------------------------------------------------
   // Duration decode, in microseconds
   // ------------------------------------------------------------
   localparam logic [14:0] FIRST_US [0:7] = '{15'h2710, 15'h4E20, 15'h3A98, 15'h1388,
                                              15'h03E8, 15'h01F4, 15'h0064, 15'h0000};
   localparam logic [14:0] SECOND_US [0:7] = '{15'h000A, 15'h0064, 15'h01F4, 15'h03E8,
                                               15'h012C, 15'h02EE, 15'h07D0, 15'h2710};

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_ADDR = 3'h1,
      ST_CMD  = 3'h3,
      ST_WLO  = 3'h2,
      ST_WHI  = 3'h6,
      ST_RLO  = 3'h7,
      ST_RHI  = 3'h5,
      ST_IGN  = 3'h4
   } chlt_st_t;

   typedef struct packed {
      chlt_st_t    st;
      logic [3:0]  cnt;
      logic [7:0]  shift;
      logic [7:0]  tx;
      logic [7:0]  cmd;
      logic [7:0]  lo;
      logic        mack;
      logic        scl_q;
      logic        sda_q;
      logic        sda_oe;
      logic        sda_out;
      logic [15:0] upper;
      logic [15:0] lower;
      logic [15:0] dur;
      logic [15:0] thr;
      logic [14:0] first_us;
      logic [14:0] second_us;
      logic [10:0] reg_target;
      logic        below_lower;
      logic        trickle;
      logic [23:0] deb_cnt;
      logic [23:0] hold_cnt;
      logic        alert_oe;
      logic        alert_out;
   } chlt_state_t;

endpackage
`default_nettype wire

// *** chlt_regs.sv ***
// Purpose: SMBus word registers for system voltage limits, limit durations and
//          the adapter overcurrent alert, with the alert timing itself
// Assumes: All inputs synchronous to ref_clk_i; current and voltage codes scaled as the registers
// Notes:   Open-drain data pin is split into level, output and enable; the alert pin into output and enable
`default_nettype none
`timescale 1ns/1ps
module chlt_regs #(
   parameter logic [6:0] DEV_ADDR     = 7'h2A,   // Arbitrary bus address
   parameter int         DEB_STEP_CYC = 1000,    // Debounce step per select value
   parameter int         HOLD_STEP_CYC = 100000  // Minimum-hold step per select value
) (
   // Clock and reset
   input  wire logic        ref_clk_i,
   input  wire logic        nrst_i,
   // SMBus pins
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe_o,
   // Sensed values and charger state
   input  wire logic [15:0] adapter_current_i,
   input  wire logic [10:0] battery_voltage_i,
   input  wire logic        battery_present_i,
   input  wire logic        charging_i,
   input  wire logic [15:0] second_control_register_i,
   // Decoded settings
   output logic [14:0]      first_level_duration_us_o,
   output logic [14:0]      second_level_duration_us_o,
   output logic [10:0]      charge_voltage_limit_o,
   output logic [10:0]      sys_regulation_target_o,
   output logic             below_lower_o,
   output logic             trickle_mode_o,
   // Alert open-drain pin
   output logic             hot_alert_o,
   output logic             hot_alert_oe_o
);

   // ------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------
   if (DEB_STEP_CYC < 1 || DEB_STEP_CYC * 4 > 16777215) begin : g_deb_chk
      $error("DEB_STEP_CYC out of range");
   end
   if (HOLD_STEP_CYC < 1 || HOLD_STEP_CYC * 8 > 16777215) begin : g_hold_chk
      $error("HOLD_STEP_CYC out of range");
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [15:0] volt_word(input logic [15:0] w);
      logic [10:0] f;
      f = w[chlt_pkg::VOLT_MSB_POS:chlt_pkg::VOLT_LSB_POS];
      if (f > chlt_pkg::VOLT_MAX_CODE) begin
         f = chlt_pkg::VOLT_MAX_CODE;
      end
      return {2'h0, f, 3'h0};
   endfunction

   function automatic logic [15:0] thr_word(input logic [15:0] w);
      logic [5:0] f;
      f = w[chlt_pkg::THR_MSB_POS:chlt_pkg::THR_LSB_POS];
      if (f > chlt_pkg::THR_MAX_CODE) begin
         f = chlt_pkg::THR_MAX_CODE;
      end
      return {3'h0, f, 7'h00};
   endfunction

   function automatic logic [15:0] dur_word(input logic [15:0] w);
      return {5'h00, w[chlt_pkg::DUR2_MSB_POS:chlt_pkg::DUR2_LSB_POS],
              5'h00, w[chlt_pkg::DUR1_MSB_POS:chlt_pkg::DUR1_LSB_POS]};
   endfunction

   chlt_pkg::chlt_state_t s_r;
   chlt_pkg::chlt_state_t s_nxt;

   logic        scl_rise;
   logic        scl_fall;
   logic        bus_start;
   logic        bus_stop;
   logic        tx_state;
   logic        wr_en;
   logic [15:0] wr_word;
   logic [15:0] rd_word;
   logic        over_now;
   logic        below_now;
   logic [10:0] upper_code;
   logic [10:0] lower_code;
   logic [1:0]  deb_sel;
   logic [2:0]  hold_sel;
   logic [23:0] deb_target;
   logic [23:0] hold_target;

   // ------------------------------------------------------------
   // Bus events and read mux
   // ------------------------------------------------------------
   always_comb begin
      scl_rise  = scl_i & ~s_r.scl_q;
      scl_fall  = ~scl_i & s_r.scl_q;
      bus_start = scl_i & s_r.scl_q & s_r.sda_q & ~sda_i;
      bus_stop  = scl_i & s_r.scl_q & ~s_r.sda_q & sda_i;
      tx_state  = (s_r.st == chlt_pkg::ST_RLO) || (s_r.st == chlt_pkg::ST_RHI);
      wr_word   = {s_r.shift, s_r.lo};
      wr_en     = ~bus_start & ~bus_stop & scl_fall & (s_r.st == chlt_pkg::ST_WHI)
                  & (s_r.cnt == chlt_pkg::ACK_DONE);
      if (s_r.cmd == chlt_pkg::CMD_UPPER_V) begin
         rd_word = s_r.upper;
      end else if (s_r.cmd == chlt_pkg::CMD_DURATIONS) begin
         rd_word = s_r.dur;
      end else if (s_r.cmd == chlt_pkg::CMD_LOWER_V) begin
         rd_word = s_r.lower;
      end else if (s_r.cmd == chlt_pkg::CMD_ALERT_THR) begin
         rd_word = s_r.thr;
      end else begin
         rd_word = 16'h0000;
      end
      upper_code  = s_r.upper[chlt_pkg::VOLT_MSB_POS:chlt_pkg::VOLT_LSB_POS];
      lower_code  = s_r.lower[chlt_pkg::VOLT_MSB_POS:chlt_pkg::VOLT_LSB_POS];
      below_now   = battery_voltage_i < lower_code;
      over_now    = adapter_current_i > s_r.thr;
      deb_sel     = second_control_register_i[chlt_pkg::CTL_DEB_MSB:chlt_pkg::CTL_DEB_LSB];
      hold_sel    = second_control_register_i[chlt_pkg::CTL_HOLD_MSB:chlt_pkg::CTL_HOLD_LSB];
      deb_target  = 24'((int'(deb_sel) + 1) * DEB_STEP_CYC);
      hold_target = 24'((int'(hold_sel) + 1) * HOLD_STEP_CYC);
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      s_nxt         = s_r;
      s_nxt.scl_q   = scl_i;
      s_nxt.sda_q   = sda_i;
      s_nxt.sda_out = 1'b0;
      s_nxt.alert_out = 1'b0;
      // Start and stop win over bit traffic so a lost host can always resync
      if (bus_start) begin
         s_nxt.st     = chlt_pkg::ST_ADDR;
         s_nxt.cnt    = 4'h0;
         s_nxt.sda_oe = 1'b0;
      end else if (bus_stop) begin
         s_nxt.st     = chlt_pkg::ST_IDLE;
         s_nxt.cnt    = 4'h0;
         s_nxt.sda_oe = 1'b0;
      end else if (s_r.st != chlt_pkg::ST_IDLE && s_r.st != chlt_pkg::ST_IGN) begin
         if (scl_rise) begin
            if (s_r.cnt < chlt_pkg::ACK_SLOT) begin
               s_nxt.shift = {s_r.shift[6:0], sda_i};
               s_nxt.cnt   = s_r.cnt + 4'h1;
            end else if (s_r.cnt == chlt_pkg::ACK_DONE) begin
               s_nxt.mack = ~sda_i;
            end
         end else if (scl_fall) begin
            if (s_r.cnt < chlt_pkg::ACK_SLOT) begin
               if (tx_state) begin
                  s_nxt.sda_oe = ~s_r.tx[~s_r.cnt[2:0]];
               end
            end else if (s_r.cnt == chlt_pkg::ACK_SLOT) begin
               s_nxt.cnt = chlt_pkg::ACK_DONE;
               if (tx_state) begin
                  s_nxt.sda_oe = 1'b0;
               end else if (s_r.st == chlt_pkg::ST_ADDR && s_r.shift[7:1] != DEV_ADDR) begin
                  s_nxt.st     = chlt_pkg::ST_IGN;
                  s_nxt.sda_oe = 1'b0;
               end else begin
                  s_nxt.sda_oe = 1'b1;
               end
            end else begin
               s_nxt.cnt    = 4'h0;
               s_nxt.sda_oe = 1'b0;
               case (s_r.st)
                  chlt_pkg::ST_ADDR: begin
                     if (s_r.shift[0]) begin
                        s_nxt.st     = chlt_pkg::ST_RLO;
                        s_nxt.tx     = rd_word[7:0];
                        s_nxt.sda_oe = ~rd_word[7];
                     end else begin
                        s_nxt.st = chlt_pkg::ST_CMD;
                     end
                  end
                  chlt_pkg::ST_CMD: begin
                     s_nxt.cmd = s_r.shift;
                     s_nxt.st  = chlt_pkg::ST_WLO;
                  end
                  chlt_pkg::ST_WLO: begin
                     s_nxt.lo = s_r.shift;
                     s_nxt.st = chlt_pkg::ST_WHI;
                  end
                  chlt_pkg::ST_RLO: begin
                     if (s_r.mack) begin
                        s_nxt.st     = chlt_pkg::ST_RHI;
                        s_nxt.tx     = rd_word[15:8];
                        s_nxt.sda_oe = ~rd_word[15];
                     end else begin
                        s_nxt.st = chlt_pkg::ST_IGN;
                     end
                  end
                  default: begin
                     s_nxt.st = chlt_pkg::ST_IGN;
                  end
               endcase
            end
         end
      end
      // Register commit after the high byte is acknowledged
      if (wr_en) begin
         if (s_r.cmd == chlt_pkg::CMD_UPPER_V) begin
            s_nxt.upper = volt_word(wr_word);
         end else if (s_r.cmd == chlt_pkg::CMD_DURATIONS) begin
            s_nxt.dur = dur_word(wr_word);
         end else if (s_r.cmd == chlt_pkg::CMD_LOWER_V) begin
            s_nxt.lower = volt_word(wr_word);
         end else if (s_r.cmd == chlt_pkg::CMD_ALERT_THR) begin
            s_nxt.thr = thr_word(wr_word);
         end
      end
      // Decoded settings
      s_nxt.first_us    = chlt_pkg::FIRST_US[s_r.dur[chlt_pkg::DUR1_MSB_POS:chlt_pkg::DUR1_LSB_POS]];
      s_nxt.second_us   = chlt_pkg::SECOND_US[s_r.dur[chlt_pkg::DUR2_MSB_POS:chlt_pkg::DUR2_LSB_POS]];
      s_nxt.below_lower = below_now;
      s_nxt.trickle     = battery_present_i & charging_i & below_now;
      s_nxt.reg_target  = s_nxt.trickle ? lower_code : upper_code;
      // Alert: debounce, then hold for the minimum time even if current drops
      if (s_r.alert_oe) begin
         s_nxt.deb_cnt = 24'h000000;
         if (s_r.hold_cnt != 24'h000000) begin
            s_nxt.hold_cnt = s_r.hold_cnt - 24'h000001;
         end else if (!over_now) begin
            s_nxt.alert_oe = 1'b0;
         end
      end else if (over_now) begin
         if (s_r.deb_cnt + 24'h000001 >= deb_target) begin
            s_nxt.alert_oe = 1'b1;
            s_nxt.hold_cnt = hold_target - 24'h000001;
            s_nxt.deb_cnt  = 24'h000000;
         end else begin
            s_nxt.deb_cnt = s_r.deb_cnt + 24'h000001;
         end
      end else begin
         s_nxt.deb_cnt = 24'h000000;
      end
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         s_r       <= '0;
         s_r.st    <= chlt_pkg::ST_IDLE;
         s_r.scl_q <= 1'b1;
         s_r.sda_q <= 1'b1;
         s_r.upper <= chlt_pkg::RST_UPPER_V;
         s_r.lower <= chlt_pkg::RST_LOWER_V;
         s_r.dur   <= chlt_pkg::RST_DURATIONS;
         s_r.thr   <= chlt_pkg::RST_ALERT_THR;
         s_r.first_us  <= chlt_pkg::FIRST_US[0];
         s_r.second_us <= chlt_pkg::SECOND_US[0];
      end else begin
         s_r <= s_nxt;
      end
   end

   assign sda_o                      = s_r.sda_out;
   assign sda_oe_o                   = s_r.sda_oe;
   assign first_level_duration_us_o  = s_r.first_us;
   assign second_level_duration_us_o = s_r.second_us;
   assign charge_voltage_limit_o     = upper_code;
   assign sys_regulation_target_o    = s_r.reg_target;
   assign below_lower_o              = s_r.below_lower;
   assign trickle_mode_o             = s_r.trickle;
   assign hot_alert_o                = s_r.alert_out;
   assign hot_alert_oe_o             = s_r.alert_oe;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!nrst_i);

   // Decode lags its register by one clock, so it is only compared once the register has settled
   AST_T1_DECODE: assert property ($stable(s_r.dur) |-> s_r.first_us == chlt_pkg::FIRST_US[s_r.dur[2:0]])
      else $error("first duration decode wrong");
   AST_T2_DECODE: assert property ($stable(s_r.dur) |-> s_r.second_us == chlt_pkg::SECOND_US[s_r.dur[10:8]])
      else $error("second duration decode wrong");
   AST_DUR_WRITE: assert property (wr_en && s_r.cmd == chlt_pkg::CMD_DURATIONS |=> s_r.dur == dur_word($past(wr_word)))
      else $error("duration write wrong");
   AST_UPPER_WRITE: assert property (wr_en && s_r.cmd == chlt_pkg::CMD_UPPER_V |=> s_r.upper == volt_word($past(wr_word)))
      else $error("upper voltage write wrong");
   AST_VOLT_CLAMP: assert property (upper_code <= chlt_pkg::VOLT_MAX_CODE && lower_code <= chlt_pkg::VOLT_MAX_CODE)
      else $error("voltage above clamp");
   AST_TARGET: assert property (##1 s_r.reg_target == ($past(s_nxt.trickle) ? $past(lower_code) : $past(upper_code)))
      else $error("regulation target wrong");
   AST_LOWER_WRITE: assert property (wr_en && s_r.cmd == chlt_pkg::CMD_LOWER_V |=> s_r.lower == volt_word($past(wr_word)))
      else $error("lower voltage write wrong");
   AST_TRICKLE: assert property (battery_present_i && charging_i && below_now |=> trickle_mode_o && below_lower_o)
      else $error("trickle entry missed");
   AST_THR_CLAMP: assert property (s_r.thr[12:7] <= chlt_pkg::THR_MAX_CODE)
      else $error("threshold above clamp");
   AST_THR_RESET: assert property (@(posedge ref_clk_i) disable iff (1'b0) !nrst_i |=> s_r.thr == 16'h0C00)
      else $error("threshold reset value wrong");
   AST_UNUSED_ZERO: assert property (s_r.upper[2:0] == 3'h0 && s_r.lower[15:14] == 2'h0 && s_r.thr[6:0] == 7'h00
                                     && s_r.upper[15:14] == 2'h0 && s_r.lower[2:0] == 3'h0 && s_r.thr[15:13] == 3'h0
                                     && s_r.dur[7:3] == 5'h00 && s_r.dur[15:11] == 5'h00)
      else $error("unused bits not zero");
   AST_THR_WRITE: assert property (wr_en && s_r.cmd == chlt_pkg::CMD_ALERT_THR |=> s_r.thr == thr_word($past(wr_word)))
      else $error("threshold write wrong");
   AST_TRICKLE_EXIT: assert property (!(battery_present_i && charging_i && below_now) |=> !trickle_mode_o)
      else $error("trickle exit missed");
   AST_ALERT_IDLE: assert property (!hot_alert_oe_o && !over_now |=> !hot_alert_oe_o)
      else $error("alert without overcurrent");
   AST_DEB_RESTART: assert property (!hot_alert_oe_o && !over_now |=> s_r.deb_cnt == 24'h000000)
      else $error("debounce not restarted");
   AST_IGN_QUIET: assert property (s_r.st == chlt_pkg::ST_IGN |-> !sda_oe_o)
      else $error("data driven while ignoring");
   AST_ALERT_HOLD: assert property (hot_alert_oe_o && s_r.hold_cnt != 24'h000000 |=> hot_alert_oe_o)
      else $error("alert released early");
   AST_ALERT_CAUSE: assert property ($rose(hot_alert_oe_o) |-> $past(over_now))
      else $error("alert without overcurrent");
   AST_BYTE_ACK: assert property (s_r.st == chlt_pkg::ST_CMD && scl_fall && s_r.cnt == 4'h8 && !bus_start && !bus_stop
                                  |=> sda_oe_o ##1 sda_oe_o)
      else $error("command byte not acknowledged");

endmodule
`default_nettype wire

// *** chlt_host.sv ***
// Purpose: SMBus host model issuing word writes and word reads
// Assumes: Bench resolves the open-drain data wire with a pull-up
// Notes:   Each SCL phase lasts 4 clocks, above the 3-clock minimum
`default_nettype none
`timescale 1ns/1ps
module chlt_host #(
   parameter logic [6:0] ADDR = 7'h2A   // Arbitrary bus address
) (
   // Clock and bus
   input  wire logic ref_clk_i,
   input  wire logic sda_i,
   output var  logic scl_o,
   output var  logic sda_pull_o
);
   initial begin
      scl_o = 1'b1;
      sda_pull_o = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask
   // SDA moves only while SCL is low, so no false start or stop
   task automatic put_bit(input logic b, output logic got);
      sda_pull_o <= ~b;
      tick(2);
      scl_o <= 1'b1;
      tick(2);
      got = sda_i;
      tick(2);
      scl_o <= 1'b0;
      tick(2);
   endtask
   task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx, output logic ack);
      logic g;
      for (int i = 7; i >= 0; i--) begin
         put_bit(tx[i], g);
         rx[i] = g;
      end
      put_bit(last, g);
      ack = ~g;
   endtask
   task automatic start();
      sda_pull_o <= 1'b0;
      tick(2);
      scl_o <= 1'b1;
      tick(4);
      sda_pull_o <= 1'b1;
      tick(4);
      scl_o <= 1'b0;
      tick(2);
   endtask
   task automatic stop();
      sda_pull_o <= 1'b1;
      tick(2);
      scl_o <= 1'b1;
      tick(4);
      sda_pull_o <= 1'b0;
      tick(4);
   endtask
   task automatic write_word(input logic [6:0] adr, input logic [7:0] c, input logic [15:0] d, output logic ok);
      logic [7:0] rx;
      logic [3:0] a;
      start();
      xfer({adr, 1'b0}, 1'b1, rx, a[0]);
      xfer(c, 1'b1, rx, a[1]);
      xfer(d[7:0], 1'b1, rx, a[2]);
      xfer(d[15:8], 1'b1, rx, a[3]);
      stop();
      ok = &a;
   endtask
   task automatic read_word(input logic [7:0] c, output logic [15:0] d, output logic ok);
      logic [7:0] rx;
      logic [3:0] a;
      start();
      xfer({ADDR, 1'b0}, 1'b1, rx, a[0]);
      xfer(c, 1'b1, rx, a[1]);
      start();
      xfer({ADDR, 1'b1}, 1'b1, rx, a[2]);
      xfer(8'hFF, 1'b0, rx, a[3]);
      d[7:0] = rx;
      xfer(8'hFF, 1'b1, rx, a[3]);
      d[15:8] = rx;
      stop();
      ok = &a[2:0];
   endtask
endmodule
`default_nettype wire

// *** test_charger_limit_timing_registers.sv ***
// Purpose: Self-checking bench for the charger limit and timing registers
// Assumes: Host model drives the bus; bench drives the sensed values
// Notes:   Short debounce and hold steps keep the alert cases quick
`default_nettype none
`timescale 1ns/1ps
module test_charger_limit_timing_registers;
   typedef struct packed {logic [7:0] cmd; logic [15:0] wdat; logic [15:0] rexp;} chlt_row_t;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic        scl, pull, sda_out, sda_oe, alert, alert_oe, below, trickle, ok;
   logic        pres = 1'b0;
   logic        chg = 1'b0;
   logic [15:0] cur = 16'h0000;
   logic [15:0] ctl = 16'h0000;
   logic [10:0] bat = 11'h000;
   logic [10:0] lim, tgt;
   logic [14:0] d1, d2;
   wire         sda = pull ? 1'b0 : (sda_oe ? sda_out : 1'b1);
   int          errors = 0;
   int          checks_done = 0;
   int          n, m;
   logic [14:0] first_us [8] = '{15'h2710, 15'h4E20, 15'h3A98, 15'h1388, 15'h03E8, 15'h01F4, 15'h0064, 15'h0000};
   logic [14:0] second_us [8] = '{15'h000A, 15'h0064, 15'h01F4, 15'h03E8, 15'h012C, 15'h02EE, 15'h07D0, 15'h2710};
   chlt_row_t   rows [9] = '{
      '{8'h15, 16'hFFFF, 16'h3600},
      '{8'h15, 16'h1234, 16'h1230},
      '{8'h3E, 16'hC00F, 16'h0008},
      '{8'h3E, 16'h3607, 16'h3600},
      '{8'h3E, 16'h3608, 16'h3600},
      '{8'h38, 16'hFFFF, 16'h0707},
      '{8'h47, 16'hFFFF, 16'h1900},
      '{8'h47, 16'h18FF, 16'h1880},
      '{8'h10, 16'hFFFF, 16'h0000}};
   always #5 clk = ~clk;
   chlt_regs #(.DEB_STEP_CYC(4), .HOLD_STEP_CYC(8)) u_dut (
      .ref_clk_i(clk), .nrst_i(nrst), .scl_i(scl), .sda_i(sda), .sda_o(sda_out), .sda_oe_o(sda_oe),
      .adapter_current_i(cur), .battery_voltage_i(bat), .battery_present_i(pres), .charging_i(chg),
      .second_control_register_i(ctl), .first_level_duration_us_o(d1), .second_level_duration_us_o(d2),
      .charge_voltage_limit_o(lim), .sys_regulation_target_o(tgt), .below_lower_o(below),
      .trickle_mode_o(trickle), .hot_alert_o(alert), .hot_alert_oe_o(alert_oe));
   chlt_host u_host (.ref_clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_pull_o(pull));
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      logic a;
      u_host.write_word(7'h2A, c, d, a);
      chk("write ack", 16'h0001, {15'h0, a});
   endtask
   task automatic rd(input logic [7:0] c, input logic [15:0] e);
      logic a;
      logic [15:0] v;
      u_host.read_word(c, v, a);
      chk("read ack", 16'h0001, {15'h0, a});
      chk($sformatf("register %h", c), e, v);
   endtask
   task automatic look(input logic [15:0] e1, input logic [15:0] e2);
      repeat (3) @(posedge clk);
      chk("trickle", e1, {15'h0, trickle});
      chk("target", e2, {5'h0, tgt});
   endtask
   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   initial begin
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      rd(8'h47, 16'h0C00);
      rd(8'h3E, 16'h0000);
      chk("first reset", 16'h2710, {1'b0, d1});
      chk("second reset", 16'h000A, {1'b0, d2});
      foreach (rows[i]) begin
         wr(rows[i].cmd, rows[i].wdat);
         rd(rows[i].cmd, rows[i].rexp);
      end
      chk("limit", 16'h0246, {5'h0, lim});
      for (int c = 0; c < 8; c++) begin
         wr(8'h38, {5'h1F, c[2:0], 5'h1F, c[2:0]});
         repeat (3) @(posedge clk);
         chk("first duration", {1'b0, first_us[c]}, {1'b0, d1});
         chk("second duration", {1'b0, second_us[c]}, {1'b0, d2});
      end
      u_host.write_word(7'h2B, 8'h15, 16'h0008, ok);
      chk("foreign ack", 16'h0000, {15'h0, ok});
      rd(8'h15, 16'h1230);
      wr(8'h3E, 16'h0800);
      bat <= 11'h0FF;
      pres <= 1'b1;
      chg <= 1'b1;
      look(16'h0001, 16'h0100);
      chk("below", 16'h0001, {15'h0, below});
      chg <= 1'b0;
      look(16'h0000, 16'h0246);
      chg <= 1'b1;
      bat <= 11'h100;
      look(16'h0000, 16'h0246);
      pres <= 1'b0;
      bat <= 11'h000;
      look(16'h0000, 16'h0246);
      // Current equal to the threshold must not count as over
      ctl <= 16'h0240;
      cur <= 16'h1880;
      repeat (20) @(posedge clk);
      chk("alert at threshold", 16'h0000, {15'h0, alert_oe});
      cur <= 16'h1900;
      repeat (5) @(posedge clk);
      cur <= 16'h1880;
      @(posedge clk);
      cur <= 16'h1900;
      n = 0;
      while (alert_oe !== 1'b1 && n < 40) begin
         @(posedge clk);
         n++;
      end
      chk("debounce window", 16'h0001, {15'h0, n >= 7 && n <= 11});
      cur <= 16'h1880;
      m = 0;
      while (alert_oe !== 1'b0 && m < 60) begin
         @(posedge clk);
         m++;
      end
      chk("hold window", 16'h0001, {15'h0, m >= 15 && m <= 20});
      chk("open drain levels", 16'h0000, {14'h0, sda_out, alert});
      nrst <= 1'b0;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      rd(8'h47, 16'h0C00);
      rd(8'h15, 16'h0000);
      tally_and_finish();
   end
   // Bound well above the roughly 11500 cycles the sequence needs
   initial begin
      repeat (60000) @(posedge clk);
      errors++;
      $display("unexpected run length: expected end seen hang");
      tally_and_finish();
   end
endmodule
`default_nettype wire
